// ==== bench/dac_alarm_props.sv ====
// Concurrent checks on the dual alarm comparator ports
`timescale 1ns/1ps
module dac_alarm_props
  import dac_pkg::*;
(
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst,
  // Watched ports
  input wire dac_reg_req_s reg_req,
  input wire logic [15:0]  reg_rdata,
  input wire dac_samples_s samples,
  input wire logic [15:0]  nv_thr_first_save,
  input wire logic         nv_save_req,
  input wire logic         io_first_oe,
  input wire logic         io_second_oe,
  input wire logic [1:0]   alarm_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Access decodes
  wire stat_rd = reg_req.rd && (reg_req.addr == ADDR_STATUS);
  wire thr_wr  = reg_req.wr && (reg_req.addr == ADDR_THR_FIRST);
  property p_save; thr_wr |=> nv_save_req && nv_thr_first_save == ($past(reg_req.wdata) & 16'hBFFF); endproperty
  a_save: assert property (p_save) else $error("threshold save wrong");
  property p_stat; stat_rd |=> reg_rdata == {6'h00, $past(alarm_active), 8'h00}; endproperty
  a_stat: assert property (p_stat) else $error("status word wrong");
  property p_clear; stat_rd && !samples.valid |=> alarm_active == 2'h0; endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  property p_rise; (alarm_active & ~$past(alarm_active)) != 2'h0 |-> $past(samples.valid); endproperty
  a_rise: assert property (p_rise) else $error("alarm without sample");
  property p_fall; (~alarm_active & $past(alarm_active)) != 2'h0 |-> $past(stat_rd); endproperty
  a_fall: assert property (p_fall) else $error("alarm dropped unread");
  property p_hold; !reg_req.rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; reg_req.rd && reg_req.addr == 7'h30 |=> reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_line; !(io_first_oe && io_second_oe); endproperty
  a_line: assert property (p_line) else $error("both lines driven");
endmodule : dac_alarm_props

// ==== bench/test_dac_alarm.sv ====
// Self-checking bench for the dual alarm comparator
`timescale 1ns/1ps
module test_dac_alarm;
  import dac_pkg::*;
  // Row: control, thresholds, status pair, io {oe1,out1,oe2,out2}
  typedef struct packed {logic [15:0] c, t1, t2; logic [1:0] st; logic [3:0] io;} dac_row_s;
  logic         core_clk, rst, nv_load, nv_save_req;
  logic         io_first_out, io_first_oe, io_second_out, io_second_oe;
  logic [15:0]  reg_rdata, nv_thr_first, nv_thr_first_save;
  logic [1:0]   alarm_active;
  dac_reg_req_s reg_req;
  dac_samples_s samples;
  int           failures = 0, n_checks = 0, cycles = 0;
  logic [6:0]   addrs [7] = '{7'h20, 7'h22, 7'h24, 7'h26, 7'h28, 7'h30, 7'h3C};
  logic [15:0]  masks [7] = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'hFF17, 16'h0, 16'h0};
  dac_row_s     rows [9] = '{'{16'h0106, 16'hC0FF, 16'h0, 2'h1, 4'hD},
    '{16'h0104, 16'h00FF, 16'h0, 2'h0, 4'hD}, '{16'h0115, 16'h0A00, 16'h0, 2'h1, 4'h2},
    '{16'h2007, 16'h0, 16'h81FF, 2'h2, 4'h7}, '{16'h5006, 16'h0, 16'h82FF, 2'h2, 4'hD},
    '{16'h6000, 16'h0, 16'h83FF, 2'h2, 4'h0}, '{16'h4306, 16'h8000, 16'h8000, 2'h0, 4'h8},
    '{16'h7706, 16'h8000, 16'h8000, 2'h0, 4'h8}, '{16'h0006, 16'h8000, 16'h8000, 2'h0, 4'h8}};

  dac_alarm dac_alarm_i (.core_clk, .rst, .reg_req, .reg_rdata, .samples, .nv_load, .nv_thr_first,
    .nv_thr_first_save, .nv_save_req, .io_first_out, .io_first_oe, .io_second_out,
    .io_second_oe, .alarm_active);

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus strobes last one cycle, set and dropped at falling edges
  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(negedge core_clk) reg_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk) reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(logic [6:0] a);
    @(negedge core_clk) reg_req = '{1'b0, 1'b1, a, 16'h0};
    @(negedge core_clk) reg_req.rd = 1'b0;
  endtask : rd
  // One supply sample, then wait until the io lines have followed the latch
  task automatic smp(logic [13:0] s);
    @(negedge core_clk) samples.valid = 1'b1;
    samples.supply_raw = s;
    @(negedge core_clk) samples.valid = 1'b0;
    @(negedge core_clk);
  endtask : smp
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard, well above the some 200 cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_req = '0;
    nv_load = 1'b0;
    nv_thr_first = 16'h1234;
    samples = '{1'b0, 14'h100, 14'h900, 14'h200, 14'hA00, 14'h300, 14'hB00, 14'h400, 14'hC00};
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(addrs[i]);
      chk(reg_rdata, 16'h0000);
      wr(addrs[i], 16'hFFFF);
      rd(addrs[i]);
      chk(reg_rdata, masks[i]);
    end
    $display("Register test done");
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i].c);
      wr(ADDR_THR_FIRST, rows[i].t1);
      wr(ADDR_THR_SECOND, rows[i].t2);
      rd(ADDR_STATUS);
      smp(14'h100);
      chk({io_first_oe, io_first_out, io_second_oe, io_second_out}, rows[i].io);
      rd(ADDR_STATUS);
      chk(reg_rdata, {6'h00, rows[i].st, 8'h00});
    end
    $display("Alarm rows done");
    // Slope mode on both: steps of 10, mean over 2; only the sample after the mean may hit
    wr(ADDR_CNT_FIRST, 16'h0002);
    wr(ADDR_CNT_SECOND, 16'h0002);
    wr(ADDR_THR_FIRST, 16'h8004);
    wr(ADDR_THR_SECOND, 16'h000C);
    wr(ADDR_CTRL, 16'h9906);
    rd(ADDR_STATUS);
    smp(14'h100);
    smp(14'h10A);
    smp(14'h114);
    rd(ADDR_STATUS);
    chk(reg_rdata, 16'h0000);
    smp(14'h11E);
    rd(ADDR_STATUS);
    chk(reg_rdata, 16'h0300);
    $display("Slope test done");
    @(negedge core_clk) nv_load = 1'b1;
    @(negedge core_clk) nv_load = 1'b0;
    rd(ADDR_THR_FIRST);
    chk(reg_rdata, 16'h1234);
    chk(nv_thr_first_save, 16'h1234);
    $display("Retention test done");
    stop_test();
  end
endmodule : test_dac_alarm

bind dac_alarm dac_alarm_props dac_alarm_props_i (.core_clk, .rst, .reg_req, .reg_rdata,
  .samples, .nv_thr_first_save, .nv_save_req, .io_first_oe, .io_second_oe, .alarm_active);

// ==== common/dac_pkg.sv ====
// Package with register map, field positions and types for the dual alarm comparator
package dac_pkg;

  localparam logic [6:0] ADDR_THR_FIRST  = 7'h20;
  localparam logic [6:0] ADDR_THR_SECOND = 7'h22;
  localparam logic [6:0] ADDR_CNT_FIRST  = 7'h24;
  localparam logic [6:0] ADDR_CNT_SECOND = 7'h26;
  localparam logic [6:0] ADDR_CTRL       = 7'h28;
  localparam logic [6:0] ADDR_STATUS     = 7'h3C;

  localparam logic [15:0] RST_REG   = 16'h0000;
  localparam int THR_DIR_BIT        = 15;
  localparam int THR_MAG_MSB        = 13;
  localparam int CNT_MSB            = 7;
  localparam int CTRL_ROC_SECOND    = 15;
  localparam int CTRL_SRC_SECOND_LO = 12;
  localparam int CTRL_ROC_FIRST     = 11;
  localparam int CTRL_SRC_FIRST_LO  = 8;
  localparam int CTRL_FILT_BIT      = 4;
  localparam int CTRL_OUT_EN_BIT    = 2;
  localparam int CTRL_OUT_POL_BIT   = 1;
  localparam int CTRL_LINE_SEL_BIT  = 0;
  localparam int STAT_FIRST_BIT     = 8;

  localparam logic [2:0] SRC_OFF    = 3'h0;
  localparam logic [2:0] SRC_SUPPLY = 3'h1;
  localparam logic [2:0] SRC_RATE   = 3'h2;
  localparam logic [2:0] SRC_AUX    = 3'h5;
  localparam logic [2:0] SRC_TEMP   = 3'h6;

  // One sample on each of the four sources, both forms
  typedef struct packed {
    logic        valid;
    logic [13:0] supply_raw;
    logic [13:0] supply_filt;
    logic [13:0] rate_raw;
    logic [13:0] rate_filt;
    logic [13:0] aux_raw;
    logic [13:0] aux_filt;
    logic [13:0] temp_raw;
    logic [13:0] temp_filt;
  } dac_samples_s;

  // One register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } dac_reg_req_s;

endpackage : dac_pkg

// ==== verilog/dac_alarm.sv ====
// Dual alarm comparator: registers, level and rate-of-change comparison, status, I/O drive
`timescale 1ns/1ps
module dac_alarm
  import dac_pkg::*;
#(
  parameter int DATA_W = 14
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Register access from the serial port logic
  input  wire dac_reg_req_s reg_req,
  output logic [15:0]       reg_rdata,
  // Source samples
  input  wire dac_samples_s samples,
  // First threshold value restored from nonvolatile storage, loaded on nv_load
  input  wire logic         nv_load,
  input  wire logic [15:0]  nv_thr_first,
  output logic [15:0]       nv_thr_first_save,
  output logic              nv_save_req,
  // General I/O lines
  output logic              io_first_out,
  output logic              io_first_oe,
  output logic              io_second_out,
  output logic              io_second_oe,
  output logic [1:0]        alarm_active
);

  // Register storage, all cleared by reset
  logic [15:0] thr_r [2];
  logic [15:0] cnt_r [2];
  logic [15:0] ctrl_r;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [15:0] rdata_r;
  logic        nv_req_r;
  // Output line flip-flops
  logic        io0_r;
  logic        io0_oe_r;
  logic        io1_r;
  logic        io1_oe_r;

  // Address matches, shared by the write strobes and the read multiplexer
  wire at_thr0 = (reg_req.addr == ADDR_THR_FIRST);
  wire at_thr1 = (reg_req.addr == ADDR_THR_SECOND);
  wire at_cnt0 = (reg_req.addr == ADDR_CNT_FIRST);
  wire at_cnt1 = (reg_req.addr == ADDR_CNT_SECOND);
  wire at_ctrl = (reg_req.addr == ADDR_CTRL);
  wire at_stat = (reg_req.addr == ADDR_STATUS);

  // Register write strobes; the status word has no write path
  wire wr_thr0  = reg_req.wr && at_thr0;
  wire wr_thr1  = reg_req.wr && at_thr1;
  wire wr_cnt0  = reg_req.wr && at_cnt0;
  wire wr_cnt1  = reg_req.wr && at_cnt1;
  wire wr_ctrl  = reg_req.wr && at_ctrl;
  wire rd_stat  = reg_req.rd && at_stat;
  wire filt_sel = ctrl_r[CTRL_FILT_BIT];

  // Write data with unused bits forced low, so they always read back as zero
  wire [15:0] thr_wdata    = {reg_req.wdata[15], 1'b0, reg_req.wdata[13:0]};
  wire [15:0] nv_thr_wdata = {nv_thr_first[15], 1'b0, nv_thr_first[13:0]};
  wire [15:0] cnt_wdata    = {8'h00, reg_req.wdata[7:0]};
  wire [15:0] ctrl_wdata   = {reg_req.wdata[15:8], 3'h0, reg_req.wdata[4], 1'b0,
                              reg_req.wdata[2:0]};

  // Read multiplexer; an unmapped address reads as zero
  wire [15:0] rd_mux =
    at_thr0 ? {thr_r[0][15], 1'b0, thr_r[0][13:0]} :
    at_thr1 ? {thr_r[1][15], 1'b0, thr_r[1][13:0]} :
    at_cnt0 ? {8'h00, cnt_r[0][7:0]} :
    at_cnt1 ? {8'h00, cnt_r[1][7:0]} :
    at_ctrl ? ctrl_r :
    at_stat ? {6'h00, stat_r, 8'h00} : 16'h0000;

  // Source words after the filtered or unfiltered choice, shared by both channels
  wire [DATA_W-1:0] supply_sel = filt_sel ? samples.supply_filt : samples.supply_raw;
  wire [DATA_W-1:0] rate_sel   = filt_sel ? samples.rate_filt   : samples.rate_raw;
  wire [DATA_W-1:0] aux_sel    = filt_sel ? samples.aux_filt    : samples.aux_raw;
  wire [DATA_W-1:0] temp_sel   = filt_sel ? samples.temp_filt   : samples.temp_raw;

  // Threshold registers; a bus write wins over a restore in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thr_r[0] <= RST_REG;
      thr_r[1] <= RST_REG;
    end else begin
      if (wr_thr0) begin
        thr_r[0] <= thr_wdata;
      end else if (nv_load) begin
        thr_r[0] <= nv_thr_wdata;
      end
      if (wr_thr1) begin
        thr_r[1] <= thr_wdata;
      end
    end
  end

  // Sample-count registers; only the low byte is kept
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r[0] <= RST_REG;
      cnt_r[1] <= RST_REG;
    end else begin
      if (wr_cnt0) begin
        cnt_r[0] <= cnt_wdata;
      end
      if (wr_cnt1) begin
        cnt_r[1] <= cnt_wdata;
      end
    end
  end

  // Control register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= RST_REG;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_wdata;
    end
  end

  // Read data holds until the next read, so a slow serial port can fetch it late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= RST_REG;
    end else if (reg_req.rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Save request; every write of the first threshold asks for a store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_req_r <= 1'b0;
    end else begin
      nv_req_r <= wr_thr0;
    end
  end

  assign reg_rdata         = rdata_r;
  assign nv_save_req       = nv_req_r;
  assign nv_thr_first_save = thr_r[0];

  logic [1:0] hit;

  // Per-channel comparator
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam int SRC_LO = (ch == 0) ? CTRL_SRC_FIRST_LO : CTRL_SRC_SECOND_LO;
    localparam int ROC_B  = (ch == 0) ? CTRL_ROC_FIRST : CTRL_ROC_SECOND;

    wire [2:0] src    = ctrl_r[SRC_LO +: 3];
    wire       rate_of_change_select    = ctrl_r[ROC_B];
    wire       src_ok = (src == SRC_SUPPLY) || (src == SRC_RATE) ||
                        (src == SRC_AUX) || (src == SRC_TEMP);
    // Inactive codes fall through to temperature, but src_ok masks their hits
    wire [DATA_W-1:0] smp =
      (src == SRC_SUPPLY) ? supply_sel :
      (src == SRC_RATE)   ? rate_sel   :
      (src == SRC_AUX)    ? aux_sel    :
                            temp_sel;
    // A control write, an inactive source or level mode throws away a half-built average
    wire              restart = !src_ok || !rate_of_change_select || wr_ctrl;

    logic [DATA_W-1:0]  prev_r;
    logic               have_prev_r;
    logic signed [23:0] acc_r;
    logic [7:0]         n_r;
    logic signed [23:0] mean_r;
    logic               mean_ok_r;

    // Differences and averages are signed; the level path compares unsigned codes
    wire signed [23:0] diff    = 24'(signed'({1'b0, smp})) - 24'(signed'({1'b0, prev_r}));
    wire signed [23:0] acc_nxt = acc_r + diff;
    wire [7:0]         len     = (cnt_r[ch][7:0] == 8'h00) ? 8'h01 : cnt_r[ch][7:0];
    wire               last    = (n_r + 8'h01) == len;
    wire signed [23:0] mag     = 24'(signed'({1'b0, thr_r[ch][THR_MAG_MSB:0]}));
    wire               gt      = thr_r[ch][THR_DIR_BIT];
    wire               lvl_hit = gt ? (smp > thr_r[ch][THR_MAG_MSB:0])
                                    : (smp < thr_r[ch][THR_MAG_MSB:0]);
    wire               roc_hit = mean_ok_r && (gt ? (mean_r > mag) : (mean_r < mag));

    // Previous sample; the first sample after a restart only primes it
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        prev_r      <= '0;
        have_prev_r <= 1'b0;
      end else if (restart) begin
        have_prev_r <= 1'b0;
      end else if (samples.valid) begin
        prev_r      <= smp;
        have_prev_r <= 1'b1;
      end
    end

    // Running sum of sample-to-sample differences over the programmed count;
    // the divider is wide and takes acc_nxt, so it sits on the sample path, one result per window
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        acc_r     <= '0;
        n_r       <= 8'h00;
        mean_r    <= '0;
        mean_ok_r <= 1'b0;
      end else if (restart) begin
        acc_r     <= '0;
        n_r       <= 8'h00;
        mean_ok_r <= 1'b0;
      end else if (samples.valid && have_prev_r) begin
        if (last) begin
          mean_r    <= acc_nxt / 24'(signed'({1'b0, len}));
          mean_ok_r <= 1'b1;
          acc_r     <= '0;
          n_r       <= 8'h00;
        end else begin
          acc_r <= acc_nxt;
          n_r   <= n_r + 8'h01;
        end
      end
    end

    // A rate result is judged on every sample after it is formed, until the next one replaces it or a restart clears it
    assign hit[ch] = src_ok && samples.valid && (rate_of_change_select ? roc_hit : lvl_hit);
  end

  // Status next value; a new hit in the read cycle survives the clear,
  // so an event is never lost between the read and the clear
  assign stat_nxt = (rd_stat ? 2'b00 : stat_r) | hit;

  // Status latches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign alarm_active = stat_r;

  // I/O line drive from the latched alarm state
  wire any_alarm = |stat_r;
  wire out_en    = ctrl_r[CTRL_OUT_EN_BIT];
  wire lvl_out   = ctrl_r[CTRL_OUT_POL_BIT] ? any_alarm : !any_alarm;
  wire line_sel  = ctrl_r[CTRL_LINE_SEL_BIT];

  // Only one line is ever enabled; both carry the level, the other is not driven
  wire io0_oe_nxt = out_en && !line_sel;
  wire io1_oe_nxt = out_en && line_sel;

  // Output enables
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io0_oe_r <= 1'b0;
      io1_oe_r <= 1'b0;
    end else begin
      io0_oe_r <= io0_oe_nxt;
      io1_oe_r <= io1_oe_nxt;
    end
  end

  // Output levels; with low polarity the idle level is 1 while enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io0_r <= 1'b0;
      io1_r <= 1'b0;
    end else begin
      io0_r <= lvl_out;
      io1_r <= lvl_out;
    end
  end

  assign io_first_out  = io0_r;
  assign io_first_oe   = io0_oe_r;
  assign io_second_out = io1_r;
  assign io_second_oe  = io1_oe_r;

endmodule : dac_alarm
